/* design/ssfi_pkg.sv */
// Constants, field layouts and carrier types of the shift and FIFO instruction executor.
// Assumes a single clock domain; every user includes it by a wildcard import.
package ssfi_pkg;

	// ------------------------------------------------------------------
	// Register offsets (byte addresses on APB)
	// ------------------------------------------------------------------
	localparam logic [7:0]  ADDR_CFG   = 8'h00;
	localparam logic [7:0]  ADDR_STAT  = 8'h04;
	localparam logic [7:0]  ADDR_X     = 8'h08;
	localparam logic [7:0]  ADDR_Y     = 8'h0C;
	localparam logic [7:0]  ADDR_RXE0  = 8'h10;
	localparam logic [7:0]  ADDR_RXE3  = 8'h1C;

	// ------------------------------------------------------------------
	// Field positions, masks and reset values
	// ------------------------------------------------------------------
	localparam int unsigned STAT_OSRCNT_LSB = 0;
	localparam int unsigned STAT_ISRCNT_LSB = 8;
	localparam int unsigned STAT_RXSTALL    = 16;
	localparam logic [31:0] CFG_WMASK       = 32'h1F1F1F35;
	localparam logic [31:0] CFG_RESET       = 32'h00000004;
	localparam logic [5:0]  CNT_FULL        = 6'h20;
	localparam logic [31:0] WORD_ZERO       = 32'h00000000;

	// ------------------------------------------------------------------
	// Instruction codes
	// ------------------------------------------------------------------
	localparam logic [2:0]  OP_OUT      = 3'h3;
	localparam logic [2:0]  OP_PUSHPULL = 3'h4;
	localparam logic [2:0]  DST_PINS    = 3'h0;
	localparam logic [2:0]  DST_X       = 3'h1;
	localparam logic [2:0]  DST_Y       = 3'h2;
	localparam logic [2:0]  DST_NULL    = 3'h3;
	localparam logic [2:0]  DST_PINDIR  = 3'h4;
	localparam logic [2:0]  DST_PC      = 3'h5;
	localparam logic [2:0]  DST_ISR     = 3'h6;
	localparam logic [2:0]  DST_EXECUTE_DESTINATION    = 3'h7;

	// ------------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] rsvd3;
		logic [4:0] outBase;
		logic [2:0] rsvd2;
		logic [4:0] pushThreshold;
		logic [2:0] rsvd1;
		logic [4:0] pullThreshold;
		logic [1:0] rsvd0;
		logic       receiveGetJoin;
		logic       receivePutJoin;
		logic       rsvdB;
		logic       outputShiftRight;
		logic       rsvdA;
		logic       autoPull;
	} ssfi_cfg_t;

	typedef struct packed {
		logic [2:0] op;
		logic [4:0] delay;
		logic [2:0] dest;
		logic [4:0] cnt;
	} ssfi_instr_t;

endpackage : ssfi_pkg

/* design/ssfi_core.sv */
// Executor for the shift-out, push, pull and move-to-receive-entry instructions.
// Assumes the sequencer holds an instruction until instrDone pulses, and that the
// transmit and receive FIFOs run on clk and react to a pop or push pulse at once.
`timescale 1ns/100ps

// Function
// - Shift-out removes count bits, adds count to output count, saturating at 32.
// - Destination codes select pins, X, Y, discard, directions, PC, ISR, execute.
// - Shift-out into ISR sets the input shift count to the bit count.
// - Bit count field of zero means thirty-two bits.
// - Destination gets shifted bits low, zeros high; end chosen by direction.
// - Pin and direction writes go through the output pin mapping.
// - Autopull at threshold refills OSR, zeroes count; stalls on empty FIFO.
// - Execute destination hands shifted word on next cycle; own delay dropped.
// - Program counter destination jumps unconditionally to the shifted value.
// - Push sends the whole ISR as one word and clears it.
// - Push with if-full does nothing below the push threshold.
// - Blocking push stalls on full; nonblocking drops, clears ISR, flags stall.
// - Pull loads one word from the transmit FIFO into the OSR.
// - Pull with if-empty does nothing below the pull threshold.
// - Blocking pull stalls on empty; nonblocking copies X into the OSR.
// - With autopull on, pull on a full OSR is a no-op barrier.
// - Move-to-receive writes ISR into a chosen entry, only with put join.
// - Entry index from immediate low bits or from Y low bits.
// - Put join alone lets the system read four entries as status registers.
// - With both joins the system loses access to the entries.
// - One read and one write port, each granted to a single party.
module ssfi_core
	import ssfi_pkg::*;
#(
	parameter int unsigned PC_W = 5                 // Program counter width.
) (
	input  wire logic            clk,               // State machine clock.
	input  wire logic            sys_rst,           // Synchronous reset, active high.
	input  wire logic            psel,              // APB select.
	input  wire logic            penable,           // APB enable.
	input  wire logic            pwrite,            // APB direction, high for write.
	input  wire logic [7:0]      paddr,             // APB byte address.
	input  wire logic [31:0]     pwdata,            // APB write data.
	output logic      [31:0]     prdata,            // APB read data.
	output logic                 pready,            // APB ready.
	output logic                 pslverr,           // APB error on unmapped address.
	input  wire logic            instrValid,        // Instruction present.
	input  wire ssfi_instr_t     instr,             // Instruction word.
	output logic                 instrDone,         // Pulse: instruction retired.
	output logic      [4:0]      delayCycles,       // Delay to apply after retiring.
	input  wire logic [31:0]     txData,            // Transmit FIFO head word.
	input  wire logic            txEmpty,           // Transmit FIFO empty.
	output logic                 txPop,             // Pulse: pop transmit FIFO.
	input  wire logic            rxFull,            // Receive FIFO full.
	output logic                 rxPush,            // Pulse: push receive FIFO.
	output logic      [31:0]     rxData,            // Word pushed to receive FIFO.
	output logic      [31:0]     pinOut,            // Output pin levels.
	output logic      [31:0]     pinDirections,     // Output pin directions.
	output logic                 jumpValid,         // Pulse: jump to jumpAddr.
	output logic      [PC_W-1:0] jumpAddr,          // Jump target.
	output logic                 execValid,         // Pulse: execute execInstr next.
	output logic      [15:0]     execInstr          // Instruction to execute.
);

	// ------------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------------
	function automatic logic [31:0] lowMask(input logic [5:0] n);
		lowMask = (n >= CNT_FULL) ? 32'hFFFFFFFF : ((32'h00000001 << n) - 32'h00000001);
	endfunction : lowMask

	function automatic logic [5:0] threshold(input logic [4:0] t);
		threshold = (t == 5'h00) ? CNT_FULL : {1'b0, t};
	endfunction : threshold

	function automatic logic [31:0] rotl(input logic [31:0] v, input logic [4:0] b);
		rotl = (v << b) | (v >> (6'h20 - {1'b0, b}));
	endfunction : rotl

	function automatic logic addrOk(input logic [7:0] a);
		addrOk = (a[1:0] == 2'h0) && (a <= ADDR_RXE3);
	endfunction : addrOk

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	ssfi_cfg_t   cfg_q;
	logic [31:0] osr_q;
	logic [5:0]  osrCount_q;
	logic [31:0] isr_q;
	logic [5:0]  isrCount_q;
	logic [31:0] x_q;
	logic [31:0] y_q;
	logic        rxStall_q;
	logic [31:0] rxEntry_q [4];
	logic        done_q;
	logic [4:0]  delay_q;
	logic        txPop_q;
	logic        rxPush_q;
	logic [31:0] rxData_q;
	logic [31:0] pinOut_q;
	logic [31:0] pinDir_q;
	logic        jumpValid_q;
	logic [PC_W-1:0] jumpAddr_q;
	logic        execValid_q;
	logic [15:0] execInstr_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	// ------------------------------------------------------------------
	// Decode and shift datapath
	// ------------------------------------------------------------------
	logic [5:0]  bitCount;
	logic [31:0] shData;
	logic [31:0] osrShifted;
	logic [6:0]  countSum;
	logic [5:0]  satCount;
	logic        refill;
	logic        isOut, isPull, isPush, isMovRx;
	logic        pushSkip, pullSkip, stall, go;
	logic [1:0]  entryIdx;
	logic [31:0] pinMask;

	// Shift-out data and the saturated count; the refill decision looks at the new count.
	always_comb begin
		bitCount = (instr.cnt == 5'h00) ? CNT_FULL : {1'b0, instr.cnt};
		if (cfg_q.outputShiftRight) begin
			shData     = osr_q & lowMask(bitCount);
			osrShifted = osr_q >> bitCount;
		end else begin
			shData     = osr_q >> (CNT_FULL - bitCount);
			osrShifted = osr_q << bitCount;
		end
		countSum = {1'b0, osrCount_q} + {1'b0, bitCount};
		satCount = (countSum > {1'b0, CNT_FULL}) ? CNT_FULL : countSum[5:0];
		refill   = cfg_q.autoPull && (satCount >= threshold(cfg_q.pullThreshold));
		pinMask  = rotl(lowMask(bitCount), cfg_q.outBase);
	end

	// Instruction class, skip and stall terms. A stalled instruction changes nothing except delay_q and the receive-stall flag, which a stalled push sets.
	always_comb begin
		isOut    = (instr.op == OP_OUT);
		isPull   = (instr.op == OP_PUSHPULL) && instr.dest[2];
		isPush   = (instr.op == OP_PUSHPULL) && !instr.dest[2] && !instr.cnt[4];
		isMovRx  = (instr.op == OP_PUSHPULL) && !instr.dest[2] && instr.cnt[4];
		pushSkip = isPush && instr.dest[1]
			&& (isrCount_q < threshold(cfg_q.pushThreshold));
		pullSkip = isPull && ((cfg_q.autoPull && (osrCount_q == 6'h00))
			|| (instr.dest[1] && (osrCount_q < threshold(cfg_q.pullThreshold))));
		stall    = (isOut && refill && txEmpty)
			|| (isPush && !pushSkip && instr.dest[0] && rxFull)
			|| (isPull && !pullSkip && instr.dest[0] && txEmpty);
		go       = instrValid && !done_q && !stall;
		entryIdx = instr.cnt[3] ? instr.cnt[1:0] : y_q[1:0];
	end

	// ------------------------------------------------------------------
	// APB slave: one wait state, answer registered
	// ------------------------------------------------------------------
	logic apbAccess, apbWr;
	logic [31:0] readMux;
	assign apbAccess = psel && penable;
	assign apbWr     = apbAccess && pready_q && pwrite && !pslverr_q;

	// Entries read back only while the system holds the read port.
	always_comb begin
		readMux = WORD_ZERO;
		if (paddr == ADDR_CFG) begin
			readMux = cfg_q;
		end else if (paddr == ADDR_STAT) begin
			readMux[STAT_OSRCNT_LSB +: 6] = osrCount_q;
			readMux[STAT_ISRCNT_LSB +: 6] = isrCount_q;
			readMux[STAT_RXSTALL]         = rxStall_q;
		end else if (paddr == ADDR_X) begin
			readMux = x_q;
		end else if (paddr == ADDR_Y) begin
			readMux = y_q;
		end else if (addrOk(paddr) && cfg_q.receivePutJoin && !cfg_q.receiveGetJoin) begin
			readMux = rxEntry_q[paddr[3:2]];
		end
	end

	// Ready rises at the end of the first access cycle; data and error are caught with it.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pready_q  <= 1'b0;
			prdata_q  <= WORD_ZERO;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= apbAccess && !pready_q;
			if (apbAccess && !pready_q) begin
				prdata_q  <= pwrite ? WORD_ZERO : readMux;
				pslverr_q <= !addrOk(paddr);
			end else begin
				pslverr_q <= 1'b0;
			end
		end
	end

	// Configuration register; reserved bits are never stored.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cfg_q <= CFG_RESET;
		end else if (apbWr && (paddr == ADDR_CFG)) begin
			cfg_q <= pwdata & CFG_WMASK;
		end
	end

	// Receive-stall flag: hardware set wins over a write-one-to-clear.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rxStall_q <= 1'b0;
		end else if (instrValid && !done_q && isPush && !pushSkip && rxFull) begin
			rxStall_q <= 1'b1;
		end else if (apbWr && (paddr == ADDR_STAT) && pwdata[STAT_RXSTALL]) begin
			rxStall_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Execution
	// ------------------------------------------------------------------
	// Retire handshake. The gap cycle after each retire keeps a held instruction
	// from running twice and lets the FIFOs settle after a pop or push.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			done_q  <= 1'b0;
			delay_q <= 5'h00;
		end else begin
			done_q  <= go;
			delay_q <= (isOut && (instr.dest == DST_EXECUTE_DESTINATION)) ? 5'h00 : instr.delay;
		end
	end

	// Output shift register and its count.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			osr_q      <= WORD_ZERO;
			osrCount_q <= CNT_FULL;
			txPop_q    <= 1'b0;
		end else begin
			txPop_q <= go && ((isOut && refill) || (isPull && !pullSkip && !txEmpty));
			if (go && isOut) begin
				if (refill) begin
					osr_q      <= txData;
					osrCount_q <= 6'h00;
				end else begin
					osr_q      <= osrShifted;
					osrCount_q <= satCount;
				end
			end else if (go && isPull && !pullSkip) begin
				osr_q      <= txEmpty ? x_q : txData;
				osrCount_q <= 6'h00;
			end
		end
	end

	// Input shift register, push and receive FIFO data.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			isr_q      <= WORD_ZERO;
			isrCount_q <= 6'h00;
			rxPush_q   <= 1'b0;
			rxData_q   <= WORD_ZERO;
		end else begin
			rxPush_q <= go && isPush && !pushSkip && !rxFull;
			if (go && isOut && (instr.dest == DST_ISR)) begin
				isr_q      <= shData;
				isrCount_q <= bitCount;
			end else if (go && isPush && !pushSkip) begin
				rxData_q   <= isr_q;
				isr_q      <= WORD_ZERO;
				isrCount_q <= 6'h00;
			end
		end
	end

	// Scratch registers; the executor wins over a simultaneous bus write.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			x_q <= WORD_ZERO;
			y_q <= WORD_ZERO;
		end else begin
			if (go && isOut && (instr.dest == DST_X)) begin
				x_q <= shData;
			end else if (apbWr && (paddr == ADDR_X)) begin
				x_q <= pwdata;
			end
			if (go && isOut && (instr.dest == DST_Y)) begin
				y_q <= shData;
			end else if (apbWr && (paddr == ADDR_Y)) begin
				y_q <= pwdata;
			end
		end
	end

	// Pins and directions: only the mapped window of bitCount pins changes.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			pinOut_q <= WORD_ZERO;
			pinDir_q <= WORD_ZERO;
		end else if (go && isOut && (instr.dest == DST_PINS)) begin
			pinOut_q <= (pinOut_q & ~pinMask) | (rotl(shData, cfg_q.outBase) & pinMask);
		end else if (go && isOut && (instr.dest == DST_PINDIR)) begin
			pinDir_q <= (pinDir_q & ~pinMask) | (rotl(shData, cfg_q.outBase) & pinMask);
		end
	end

	// Jump and execute requests to the sequencer, one-cycle pulses.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			jumpValid_q <= 1'b0;
			jumpAddr_q  <= '0;
			execValid_q <= 1'b0;
			execInstr_q <= 16'h0000;
		end else begin
			jumpValid_q <= go && isOut && (instr.dest == DST_PC);
			execValid_q <= go && isOut && (instr.dest == DST_EXECUTE_DESTINATION);
			if (go && isOut) begin
				jumpAddr_q  <= shData[PC_W-1:0];
				execInstr_q <= shData[15:0];
			end
		end
	end

	// Entry storage: the state machine owns the write port; ignored without put join.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < 4; i++) begin
				rxEntry_q[i] <= WORD_ZERO;
			end
		end else if (go && isMovRx && cfg_q.receivePutJoin) begin
			rxEntry_q[entryIdx] <= isr_q;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign prdata        = prdata_q;
	assign pready        = pready_q;
	assign pslverr       = pslverr_q;
	assign instrDone     = done_q;
	assign delayCycles   = delay_q;
	assign txPop         = txPop_q;
	assign rxPush        = rxPush_q;
	assign rxData        = rxData_q;
	assign pinOut        = pinOut_q;
	assign pinDirections = pinDir_q;
	assign jumpValid     = jumpValid_q;
	assign jumpAddr      = jumpAddr_q;
	assign execValid     = execValid_q;
	assign execInstr     = execInstr_q;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	AST_OUT_COUNT: assert property (go && isOut && !refill |=> osrCount_q == $past(satCount))
		else $error("output count not advanced");
	AST_OUT_X: assert property (go && isOut && instr.dest == DST_X |=> x_q == $past(shData))
		else $error("scratch X not written");
	AST_OUT_ZERO_HIGH: assert property (go && isOut && instr.cnt == 5'h08
		&& instr.dest == DST_Y |=> y_q[31:8] == 24'h000000)
		else $error("upper bits of shifted word not zero");
	AST_OUT_ISR_CNT: assert property (go && isOut && instr.dest == DST_ISR
		|=> isrCount_q == $past(bitCount) && isr_q == $past(shData))
		else $error("ISR count not set");
	AST_FULL_SHIFT: assert property (go && isOut && instr.cnt == 5'h00 && !refill
		|=> osrCount_q == CNT_FULL)
		else $error("zero count not treated as 32");
	AST_REFILL: assert property (go && isOut && refill
		|=> txPop_q && osrCount_q == 6'h00 && osr_q == $past(txData))
		else $error("autopull refill wrong");
	AST_OUT_STALL: assert property (instrValid && !done_q && isOut && refill && txEmpty
		|=> !done_q && !txPop_q)
		else $error("shift-out did not stall on empty FIFO");
	AST_EXECUTE_DESTINATION: assert property (go && isOut && instr.dest == DST_EXECUTE_DESTINATION
		|=> execValid_q && delay_q == 5'h00 && execInstr_q == $past(shData[15:0])
		##1 !execValid_q)
		else $error("execute request wrong");
	AST_JUMP: assert property (go && isOut && instr.dest == DST_PC
		|=> jumpValid_q && jumpAddr_q == $past(shData[PC_W-1:0]))
		else $error("jump not issued");
	AST_PIN_MASK: assert property (go && isOut && instr.dest == DST_PINS
		|=> (pinOut_q & ~$past(pinMask)) == ($past(pinOut_q) & ~$past(pinMask)))
		else $error("pins outside the mapped window changed");
	AST_PUSH: assert property (go && isPush && !pushSkip && !rxFull
		|=> rxPush_q && rxData_q == $past(isr_q) && isr_q == WORD_ZERO)
		else $error("push wrong");
	AST_PUSH_SKIP: assert property (go && pushSkip |=> !rxPush_q && $stable(isr_q))
		else $error("if-full push acted below threshold");
	AST_PUSH_DROP: assert property (go && isPush && !pushSkip && rxFull
		|=> !rxPush_q && rxStall_q && isr_q == WORD_ZERO)
		else $error("nonblocking push to full FIFO wrong");
	AST_PULL_X: assert property (go && isPull && !pullSkip && txEmpty
		|=> !txPop_q && osr_q == $past(x_q) && osrCount_q == 6'h00)
		else $error("nonblocking pull did not copy X");
	AST_PULL_LOAD: assert property (go && isPull && !pullSkip && !txEmpty
		|=> txPop_q && osr_q == $past(txData))
		else $error("pull did not load FIFO word");
	AST_PULL_SKIP: assert property (go && pullSkip |=> !txPop_q && $stable(osr_q))
		else $error("if-empty pull acted below threshold");
	AST_BARRIER: assert property (go && isPull && cfg_q.autoPull && osrCount_q == 6'h00
		|=> !txPop_q && $stable(osr_q))
		else $error("pull on full OSR not a no-op");
	AST_ENTRY_WR: assert property (go && isMovRx && cfg_q.receivePutJoin
		|=> rxEntry_q[$past(entryIdx)] == $past(isr_q))
		else $error("receive entry not written");
	AST_GRANT: assert property (apbAccess && !pready_q && !pwrite && paddr >= ADDR_RXE0
		&& cfg_q.receiveGetJoin |=> pready_q && prdata_q == WORD_ZERO)
		else $error("system read entry while state machine owns it");

	COV_EXECUTE_DESTINATION: cover property (go && isOut && instr.dest == DST_EXECUTE_DESTINATION);
	COV_PUSH_DROP: cover property (go && isPush && !instr.dest[0] && rxFull);
	COV_PULL_NOBLOCK: cover property (go && isPull && !pullSkip && txEmpty);
	COV_MOV_RX: cover property (go && isMovRx && cfg_q.receivePutJoin);

endmodule : ssfi_core

/* dv/ssfi_fifo_model.sv */
// Transmit and receive FIFO model that faces the shift and FIFO executor.
// Assumes pops arrive as one-cycle pulses on clk; the bench loads words between instructions or while one stalls.
`timescale 1ns/100ps
module ssfi_fifo_model (
	input  wire logic        clk,     // Shared clock.
	input  wire logic        txPop,   // Pop pulse from the executor.
	input  wire logic        fullReq, // Bench asks the receive side to refuse.
	output logic      [31:0] txData,  // Head word of the transmit queue.
	output logic             txEmpty, // High while nothing is queued.
	output logic             rxFull   // Receive side full.
);
	logic [31:0] txQ[$];
	logic [31:0] lastW = 32'h00000000;

	// Queue a word for the executor; it shows from the next clock edge, so the
	// outputs keep a single driver and never change between edges.
	task automatic load(input logic [31:0] w);
		txQ.push_back(w);
	endtask : load

	// An empty queue shows the inverse of the last word, so stale data never passes.
	always @(posedge clk) begin
		if (txPop && txQ.size() > 0) begin
			lastW = txQ.pop_front();
		end
		txEmpty <= (txQ.size() == 0);
		txData  <= (txQ.size() == 0) ? ~lastW : txQ[0];
	end

	// The receive side refuses only when the bench asks.
	assign rxFull = fullReq;
endmodule : ssfi_fifo_model

/* dv/tb_sm_shift_fifo_instructions.sv */
// Self-checking bench for the shift and FIFO instruction executor.
// Assumes a one-wait-state APB slave and one instruction retired per handshake.
`timescale 1ns/100ps
module tb_sm_shift_fifo_instructions
	import ssfi_pkg::*;
;
	logic        clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        instrValid = 1'b0, fullReq = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	ssfi_instr_t instr = 16'h0000;
	logic [31:0] prdata, txData, rxData, pinOut, pinDirections, rdWord, pushWord;
	logic        pready, pslverr, instrDone, txPop, txEmpty, rxFull, rxPush;
	logic        jumpValid, execValid, errSeen, pushSeen, jumpSeen;
	logic [4:0]  delayCycles, jumpAddr, jumpTo;
	logic [15:0] execInstr;
	int          badCount = 0, checked = 0, cycles = 0;

	always #2 clk = ~clk;

	ssfi_core ssfi_core_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .instrValid(instrValid), .instr(instr), .instrDone(instrDone),
		.delayCycles(delayCycles), .txData(txData), .txEmpty(txEmpty), .txPop(txPop),
		.rxFull(rxFull), .rxPush(rxPush), .rxData(rxData), .pinOut(pinOut),
		.pinDirections(pinDirections), .jumpValid(jumpValid), .jumpAddr(jumpAddr),
		.execValid(execValid), .execInstr(execInstr));
	ssfi_fifo_model ssfi_fifo_model_i (.clk(clk), .txPop(txPop), .fullReq(fullReq),
		.txData(txData), .txEmpty(txEmpty), .rxFull(rxFull));

	// --------------------------------------------------------------
	// Shared tasks
	// --------------------------------------------------------------
	task automatic finishTest();
		$display("checks %0d mismatches %0d", checked, badCount);
		if (badCount == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finishTest

	task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			badCount++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmpWord

	// One APB transfer; held until pready is sampled high, then released.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d = 32'h00000000);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rdWord = prdata;
		errSeen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// Present one instruction and hold it until the retire pulse is sampled.
	task automatic run(input logic [15:0] w);
		@(posedge clk);
		instr <= w;
		instrValid <= 1'b1;
		do @(posedge clk); while (instrDone !== 1'b1);
		pushSeen = rxPush;
		pushWord = rxData;
		jumpSeen = jumpValid;
		jumpTo = jumpAddr;
		instrValid <= 1'b0;
	endtask : run

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic scenRegs();
		apb(1'b0, ADDR_CFG);
		cmpWord(rdWord, CFG_RESET);
		apb(1'b0, ADDR_STAT);
		cmpWord(rdWord, 32'h00000020);
		apb(1'b0, 8'h20);
		cmpWord({31'h0, errSeen}, 32'h00000001);
	endtask : scenRegs

	// Pull a word, shift 8 bits right into X, then 32 into Y.
	task automatic scenShift();
		ssfi_fifo_model_i.load(32'h12345678);
		run(16'h80A0);
		run(16'h6028);
		apb(1'b0, ADDR_X);
		cmpWord(rdWord, 32'h00000078);
		run(16'h6040);
		apb(1'b0, ADDR_Y);
		cmpWord(rdWord, 32'h00123456);
		apb(1'b0, ADDR_STAT);
		cmpWord(rdWord, 32'h00000020);
	endtask : scenShift

	// A nonblocking pull on an empty FIFO takes X; 5 bits then go to the program counter.
	task automatic scenJump();
		run(16'h8080);
		run(16'h60A5);
		cmpWord({27'h0, jumpTo}, 32'h00000018);
		cmpWord({31'h0, jumpSeen}, 32'h00000001);
	endtask : scenJump

	// Shift into the ISR, push it, then push again into a full FIFO without blocking.
	task automatic scenPush();
		run(16'h8080);
		run(16'h60C8);
		apb(1'b0, ADDR_STAT);
		cmpWord(rdWord, 32'h00000808);
		run(16'h8020);
		cmpWord(pushWord, 32'h00000078);
		fullReq <= 1'b1;
		run(16'h8000);
		cmpWord({31'h0, pushSeen}, 32'h00000000);
		apb(1'b0, ADDR_STAT);
		cmpWord(rdWord, 32'h00010008);
	endtask : scenPush

	// Autopull at threshold 16, pins based at 4: refill, pins, execute, if-empty skip.
	task automatic scenAuto();
		ssfi_fifo_model_i.load(32'h87654321);
		ssfi_fifo_model_i.load(32'h89ABCDEF);
		apb(1'b1, ADDR_CFG, 32'h04001015);
		run(16'h6068);
		cmpWord({31'h0, txPop}, 32'h00000001);
		run(16'h6308);
		cmpWord(pinOut, 32'h00000210);
		cmpWord({27'h0, delayCycles}, 32'h00000003);
		run(16'h65E8);
		cmpWord({16'h0, execInstr}, 32'h00000043);
		cmpWord({31'h0, execValid}, 32'h00000001);
		cmpWord({27'h0, delayCycles}, 32'h00000000);
		run(16'h6084);
		cmpWord(pinDirections, 32'h000000F0);
		run(16'h80C0);
		run(16'h6024);
		apb(1'b0, ADDR_X);
		cmpWord(rdWord, 32'h0000000E);
	endtask : scenAuto

	// Copy X, stop a second pull at the barrier, then park the ISR in receive entries.
	task automatic scenEntry();
		run(16'h8080);
		apb(1'b1, ADDR_X, 32'h00000055);
		run(16'h8080);
		run(16'h60C8);
		run(16'h8019);
		run(16'h8010);
		apb(1'b0, ADDR_RXE0 + 8'h04);
		cmpWord(rdWord, 32'h0000000E);
		apb(1'b0, ADDR_RXE0 + 8'h08);
		cmpWord(rdWord, 32'h0000000E);
		run(16'h8040);
		apb(1'b0, ADDR_STAT);
		cmpWord(rdWord, 32'h00010808);
		apb(1'b1, ADDR_CFG, 32'h04001035);
		apb(1'b0, ADDR_RXE0 + 8'h04);
		cmpWord(rdWord, 32'h00000000);
	endtask : scenEntry

	// An autopull on an empty FIFO holds the shift-out until a word arrives.
	task automatic scenStall();
		fork
			run(16'h6068);
			begin
				repeat (6) @(posedge clk);
				ssfi_fifo_model_i.load(32'h0000C35A);
			end
		join
		run(16'h6028);
		apb(1'b0, ADDR_X);
		cmpWord(rdWord, 32'h0000005A);
	endtask : scenStall

	// A hang ends the run as a mismatch.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			badCount++;
			finishTest();
		end
	end

	initial begin
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		scenRegs();
		scenShift();
		scenJump();
		scenPush();
		scenAuto();
		scenEntry();
		scenStall();
		finishTest();
	end
endmodule : tb_sm_shift_fifo_instructions
